// *** core/ssa_pkg.sv ***
// Shared constants and types for the serial SAR converter sequencer
package ssa_pkg;

  localparam int RES_BITS = 12;
  localparam int CNT_W = 5;
  localparam int IDX_W = 4;
  localparam int SETTLE_W = 3;

  // Conversion-clock counts measured from the select falling edge
  localparam logic [CNT_W-1:0] STROBE_TICK = 5'h10;
  localparam logic [CNT_W-1:0] FIRST_BIT_TICK = 5'h14;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

  localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;
  localparam logic [IDX_W-1:0] IDX_MSB = 4'hB;
  localparam logic [IDX_W-1:0] IDX_LAST = 4'hC;

  // Reference-clock cycles the comparator gets to settle per trial bit
  localparam logic [SETTLE_W-1:0] SAR_SETTLE_LAST = 3'h3;
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 3'h0;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE = 3'h1;

  localparam logic [RES_BITS-1:0] CODE_ZERO = 12'h000;
  localparam logic [RES_BITS-1:0] CODE_ONE = 12'h001;

  localparam logic [1:0] MODE_PINS_SINGLE = 2'h0;
  localparam logic [1:0] MODE_PINS_CONT_LSB = 2'h1;
  localparam logic [1:0] MODE_PINS_CONT_MSB = 2'h3;

  typedef enum logic [1:0] {
    SSA_SINGLE_MSB,
    SSA_CONT_LSB,
    SSA_CONT_MSB
  } ssa_mode_t;

  // Control pins as one bundle; mode bits packed {conv_mode_0, conv_mode_1}
  typedef struct packed {
    logic select_n;
    logic [1:0] chan_sel;
    logic [1:0] mode_sel;
  } ssa_pins_t;

  localparam ssa_pins_t PINS_IDLE = '{select_n: 1'b1, chan_sel: 2'h0, mode_sel: 2'h0};

  function automatic ssa_mode_t decode_mode(input logic [1:0] mode_sel);
    ssa_mode_t m;
    m = SSA_SINGLE_MSB;
    if (mode_sel == MODE_PINS_CONT_LSB) begin
      m = SSA_CONT_LSB;
    end else if (mode_sel == MODE_PINS_CONT_MSB) begin
      m = SSA_CONT_MSB;
    end
    return m;
  endfunction : decode_mode

  function automatic logic pick_bit(input logic [RES_BITS-1:0] res, input logic [IDX_W-1:0] idx,
                                    input logic lsb_first);
    logic b;
    b = lsb_first ? res[idx] : res[IDX_MSB - idx];
    return b;
  endfunction : pick_bit

endpackage : ssa_pkg

// *** core/ssa_sar.sv ***
// Successive approximation engine driving the trial DAC code
`timescale 1ns/1ps
`default_nettype none
module ssa_sar (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic cmp_high_i,
  output logic busy_o,
  output logic [ssa_pkg::RES_BITS-1:0] dac_code_o,
  output logic [ssa_pkg::RES_BITS-1:0] result_o
);

  logic busy;
  logic next_busy;
  logic [ssa_pkg::RES_BITS-1:0] code;
  logic [ssa_pkg::RES_BITS-1:0] next_code;
  logic [ssa_pkg::RES_BITS-1:0] result;
  logic [ssa_pkg::RES_BITS-1:0] next_result;
  logic [ssa_pkg::IDX_W-1:0] ptr;
  logic [ssa_pkg::IDX_W-1:0] next_ptr;
  logic [ssa_pkg::SETTLE_W-1:0] settle;
  logic [ssa_pkg::SETTLE_W-1:0] next_settle;

  // One trial bit at a time, kept when the input is at or above the trial
  always_comb begin
    next_busy = busy;
    next_code = code;
    next_result = result;
    next_ptr = ptr;
    next_settle = settle;
    if (abort_i) begin
      next_busy = 1'b0;
      next_code = ssa_pkg::CODE_ZERO;
    end else if (start_i) begin
      next_busy = 1'b1;
      next_code = ssa_pkg::CODE_ONE << ssa_pkg::IDX_MSB; // [R1]
      next_ptr = ssa_pkg::IDX_MSB;
      next_settle = ssa_pkg::SETTLE_ZERO;
    end else if (busy) begin
      next_settle = settle + ssa_pkg::SETTLE_ONE;
      if (settle == ssa_pkg::SAR_SETTLE_LAST) begin
        next_settle = ssa_pkg::SETTLE_ZERO;
        next_code[ptr] = cmp_high_i; // [R1]
        if (ptr == ssa_pkg::IDX_ZERO) begin
          next_busy = 1'b0;
          next_result = next_code;
        end else begin
          next_code[ptr - ssa_pkg::IDX_ONE] = 1'b1; // [R1]
          next_ptr = ptr - ssa_pkg::IDX_ONE;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      code <= ssa_pkg::CODE_ZERO;
      result <= ssa_pkg::CODE_ZERO;
      ptr <= ssa_pkg::IDX_ZERO;
      settle <= ssa_pkg::SETTLE_ZERO;
    end else begin
      busy <= next_busy;
      code <= next_code;
      result <= next_result;
      ptr <= next_ptr;
      settle <= next_settle;
    end
  end

  assign busy_o = busy;
  assign dac_code_o = code;
  assign result_o = result;

endmodule : ssa_sar
`default_nettype wire

// *** core/ssa_seq.sv ***
// Sequencer and serial output of the four-channel serial SAR converter
// Functional notes
// R1 - Each result is found by successive approximation, one bit per trial, from the sampled channel.
// R2 - Each 12-bit result leaves one bit per conversion clock, changing on the clock's rising edge.
// R3 - Conversion starts when select_n goes low and all activity halts while it is high.
// R4 - While select_n is high, the serial result and the sample strobe outputs float.
// R5 - Channel pins pick input 0 to 3 in binary order, channel_sel_1 being the upper bit.
// R6 - In continuous modes the host sets a new channel before the sample strobe rises.
// R7 - Mode pins give single-shot MSB, continuous LSB or continuous MSB; the host never applies the fourth code.
// R8 - The sample strobe is high one conversion clock, and the first bit appears three clocks after it falls.
// R9 - In single-shot mode the serial output holds low and conversion stops after the twelfth bit.
// R10 - For a new single-shot conversion the host toggles select_n high then low.
// R11 - Single-shot mode sends the most significant bit first.
// R12 - Continuous LSB mode converts repeatedly while selected and sends the least significant bit first.
// R13 - In continuous LSB mode the first bit appears 20 conversion clocks after select_n falls.
// R14 - Continuous MSB mode converts repeatedly while selected and sends the most significant bit first.
// R15 - Select, channel and mode pins are sampled on rising edges so all decisions are synchronous.
`timescale 1ns/1ps
`default_nettype none
module ssa_seq (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic conv_clk_i,
  input wire logic select_n_i,
  input wire logic channel_sel_0_i,
  input wire logic channel_sel_1_i,
  input wire logic conv_mode_0_i,
  input wire logic conv_mode_1_i,
  input wire logic comparator_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_n_o,
  output logic sample_strobe_o,
  output logic sample_strobe_oe_n_o,
  output logic [1:0] analog_mux_sel_o,
  output logic [ssa_pkg::RES_BITS-1:0] dac_code_o
);

  typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_GAP, ST_SHIFT, ST_HOLD} ssa_state_t;

  ssa_pkg::ssa_pins_t pin_meta;
  ssa_pkg::ssa_pins_t pins;
  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic cmp_meta;
  logic cmp_sync;
  logic tick;

  ssa_state_t state;
  ssa_state_t next_state;
  ssa_pkg::ssa_mode_t mode;
  ssa_pkg::ssa_mode_t next_mode;
  logic [ssa_pkg::CNT_W-1:0] cnt;
  logic [ssa_pkg::CNT_W-1:0] next_cnt;
  logic [ssa_pkg::IDX_W-1:0] bit_idx;
  logic [ssa_pkg::IDX_W-1:0] next_bit_idx;
  logic dout;
  logic next_dout;
  logic strobe;
  logic next_strobe;
  logic oe_n;
  logic next_oe_n;
  logic [1:0] chan;
  logic [1:0] next_chan;
  logic sar_start;
  logic next_sar_start;
  logic sar_busy;
  logic [ssa_pkg::RES_BITS-1:0] sar_result;
  logic lsb_first;

  // Pins pass two flip-flops before any logic looks at them
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_meta <= ssa_pkg::PINS_IDLE;
      pins <= ssa_pkg::PINS_IDLE;
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      pin_meta <= '{select_n: select_n_i, chan_sel: {channel_sel_1_i, channel_sel_0_i},
                    mode_sel: {conv_mode_0_i, conv_mode_1_i}}; // [R15]
      pins <= pin_meta;
      clk_meta <= conv_clk_i;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      cmp_meta <= comparator_i;
      cmp_sync <= cmp_meta;
    end
  end

  assign tick = clk_sync & ~clk_prev; // [R15]
  assign lsb_first = (mode == ssa_pkg::SSA_CONT_LSB);

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cnt = cnt;
    next_bit_idx = bit_idx;
    next_dout = dout;
    next_strobe = strobe;
    next_oe_n = oe_n;
    next_chan = chan;
    next_sar_start = 1'b0;
    if (pins.select_n) begin
      next_state = ST_OFF; // [R3]
      next_oe_n = 1'b1; // [R4]
      next_dout = 1'b0;
      next_strobe = 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_ACQ; // [R3]
          next_mode = ssa_pkg::decode_mode(pins.mode_sel); // [R7]
          next_cnt = ssa_pkg::CNT_ZERO;
          next_oe_n = 1'b0;
          next_dout = 1'b0;
        end
        ST_ACQ: begin
          if (tick) begin
            next_cnt = cnt + ssa_pkg::CNT_ONE;
            if (cnt == ssa_pkg::STROBE_TICK - ssa_pkg::CNT_ONE) begin
              next_state = ST_GAP;
              next_strobe = 1'b1; // [R8]
              next_chan = pins.chan_sel; // [R5] [R6]
              next_sar_start = 1'b1; // [R1]
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            next_cnt = cnt + ssa_pkg::CNT_ONE;
            next_strobe = 1'b0; // [R8]
            if (cnt == ssa_pkg::FIRST_BIT_TICK - ssa_pkg::CNT_ONE) begin
              next_state = ST_SHIFT; // [R8] [R13]
              next_dout = ssa_pkg::pick_bit(sar_result, ssa_pkg::IDX_ZERO, lsb_first); // [R11] [R12] [R14]
              next_bit_idx = ssa_pkg::IDX_ONE;
            end
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            next_cnt = cnt + ssa_pkg::CNT_ONE;
            if (bit_idx == ssa_pkg::IDX_LAST) begin
              next_dout = 1'b0;
              if (mode == ssa_pkg::SSA_SINGLE_MSB) begin
                next_state = ST_HOLD; // [R9]
              end else begin
                next_state = ST_ACQ; // [R12] [R14]
                next_cnt = ssa_pkg::CNT_ZERO;
              end
            end else begin
              next_dout = ssa_pkg::pick_bit(sar_result, bit_idx, lsb_first); // [R2]
              next_bit_idx = bit_idx + ssa_pkg::IDX_ONE;
            end
          end
        end
        ST_HOLD: begin
          next_dout = 1'b0; // [R9] [R10]
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_OFF;
      mode <= ssa_pkg::SSA_SINGLE_MSB;
      cnt <= ssa_pkg::CNT_ZERO;
      bit_idx <= ssa_pkg::IDX_ZERO;
      dout <= 1'b0;
      strobe <= 1'b0;
      oe_n <= 1'b1;
      chan <= 2'h0;
      sar_start <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
      dout <= next_dout;
      strobe <= next_strobe;
      oe_n <= next_oe_n;
      chan <= next_chan;
      sar_start <= next_sar_start;
    end
  end

  ssa_sar u_sar (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(sar_start),
    .abort_i(pins.select_n),
    .cmp_high_i(cmp_sync),
    .busy_o(sar_busy),
    .dac_code_o(dac_code_o),
    .result_o(sar_result)
  );

  assign serial_result_out_o = dout;
  assign sample_strobe_o = strobe;
  assign serial_result_oe_n_o = oe_n;
  assign sample_strobe_oe_n_o = oe_n;
  assign analog_mux_sel_o = chan;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  halt_on_select_a: assert property (pins.select_n |=> state == ST_OFF && !sar_busy) // [R3]
    else $error("activity continued while deselected");
  float_outputs_a: assert property (pins.select_n |=> serial_result_oe_n_o && sample_strobe_oe_n_o) // [R4]
    else $error("outputs driven while deselected");
  sar_done_a: assert property ($rose(sample_strobe_o) |=> sar_busy ##[1:60] !sar_busy) // [R1]
    else $error("approximation did not finish in time");
  bit_on_edge_a: assert property (state == ST_SHIFT && $past(state) == ST_SHIFT && $changed(dout)
                                  |-> $past(tick)) // [R2]
    else $error("serial bit changed off the clock edge");
  chan_latch_a: assert property ($rose(sample_strobe_o) |-> analog_mux_sel_o == $past(pins.chan_sel)) // [R5]
    else $error("channel not taken from pins at strobe");
  mode_decode_a: assert property (state == ST_ACQ && $past(state) == ST_OFF
                                  |-> mode == ssa_pkg::decode_mode($past(pins.mode_sel))) // [R7]
    else $error("mode decoded wrongly");
  strobe_fall_a: assert property ($fell(sample_strobe_o) && state == ST_GAP
                                  |-> $past(tick) && cnt == ssa_pkg::STROBE_TICK + ssa_pkg::CNT_ONE) // [R8]
    else $error("strobe not one clock wide");
  first_bit_a: assert property (state == ST_SHIFT && $past(state) == ST_GAP
                                |-> cnt == ssa_pkg::FIRST_BIT_TICK && !sar_busy) // [R8] [R13]
    else $error("first bit at wrong clock");
  bit_order_a: assert property (state == ST_SHIFT && $past(state) == ST_GAP
                                |-> dout == ((mode == ssa_pkg::SSA_CONT_LSB) ? sar_result[ssa_pkg::IDX_ZERO]
                                                                             : sar_result[ssa_pkg::IDX_MSB])) // [R11] [R12] [R14]
    else $error("first bit has wrong significance");
  hold_low_a: assert property (state == ST_HOLD |-> !dout && !sample_strobe_o && mode == ssa_pkg::SSA_SINGLE_MSB) // [R9]
    else $error("single shot did not stop low");

  single_done_c: cover property (state == ST_SHIFT ##1 state == ST_HOLD);
  cont_repeat_c: cover property (state == ST_SHIFT && mode == ssa_pkg::SSA_CONT_MSB ##1 state == ST_ACQ);
  lsb_shift_c: cover property (state == ST_SHIFT && mode == ssa_pkg::SSA_CONT_LSB);

endmodule : ssa_seq
`default_nettype wire

// *** sim/ssa_host_model.sv ***
// Host side model: conversion clock source and analog comparator of the converter
`timescale 1ns/1ps
`default_nettype none
module ssa_host_model (
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic [1:0] mux_sel_i,
  input wire logic [11:0] dac_code_i,
  input wire logic [47:0] levels_i,
  output logic conv_clk_o,
  output logic comparator_o
);
  logic [2:0] half_cnt = 3'h0;
  logic clk_q = 1'b0;
  logic cmp_q = 1'b0;

  // Clock runs only while a conversion is wanted, eight reference cycles per half
  always @(negedge ref_clk_i) begin
    if (!run_i) begin
      clk_q <= 1'b0;
      half_cnt <= 3'h0;
    end else begin
      half_cnt <= half_cnt + 3'h1;
      if (half_cnt == 3'h7) begin
        clk_q <= ~clk_q;
      end
    end
  end

  // Selected analog level compared with the trial code
  always @(negedge ref_clk_i) begin
    cmp_q <= levels_i[int'(mux_sel_i) * 12 +: 12] >= dac_code_i;
  end

  assign conv_clk_o = clk_q;
  assign comparator_o = cmp_q;
endmodule : ssa_host_model
`default_nettype wire

// *** sim/ssa_tb.sv ***
// Self-checking bench for the serial SAR converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("BAD %0t %s", $time, msg); end end
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  ssa_pkg::ssa_pins_t pins = ssa_pkg::PINS_IDLE;
  logic [47:0] levels = {12'h3A1, 12'hA5C, 12'hFFF, 12'h000};
  logic conv_clk, comparator, data, data_oe_n, strobe, strobe_oe_n;
  logic [1:0] mux_sel;
  logic [ssa_pkg::RES_BITS-1:0] dac_code;
  int error_cnt = 0;
  int cmp_count = 0;

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  ssa_seq uut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .conv_clk_i(conv_clk), .select_n_i(pins.select_n),
    .channel_sel_0_i(pins.chan_sel[0]), .channel_sel_1_i(pins.chan_sel[1]), .conv_mode_0_i(pins.mode_sel[1]),
    .conv_mode_1_i(pins.mode_sel[0]), .comparator_i(comparator), .serial_result_out_o(data),
    .serial_result_oe_n_o(data_oe_n), .sample_strobe_o(strobe), .sample_strobe_oe_n_o(strobe_oe_n),
    .analog_mux_sel_o(mux_sel), .dac_code_o(dac_code));

  ssa_host_model host (.ref_clk_i(ref_clk), .run_i(run), .mux_sel_i(mux_sel), .dac_code_i(dac_code),
    .levels_i(levels), .conv_clk_o(conv_clk), .comparator_o(comparator));

  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Waits for the next falling edge of the conversion clock, mid-bit
  task automatic wait_fall();
    int n;
    logic last;
    logic done;
    n = 0;
    last = conv_clk;
    do begin
      @(negedge ref_clk);
      n++;
      if (n > 40) begin
        error_cnt++;
        $display("BAD %0t conversion clock stalled", $time);
        wrap_up();
      end
      done = (last === 1'b1) && (conv_clk === 1'b0);
      last = conv_clk;
    end while (!done);
  endtask : wait_fall

  // Mode bits packed {conv_mode_0, conv_mode_1}
  task automatic start(input logic [1:0] mode, input logic [1:0] ch);
    @(negedge ref_clk);
    pins.mode_sel <= mode;
    pins.chan_sel <= ch;
    pins.select_n <= 1'b0;
    run <= 1'b1;
  endtask : start

  task automatic stop();
    @(negedge ref_clk);
    pins.select_n <= 1'b1;
    run <= 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHK({data_oe_n, strobe_oe_n, data, strobe}, 4'hC, "outputs not floated")
  endtask : stop

  // Judges the outputs after conversion clock tick t
  task automatic check_tick(input int t, input logic [1:0] ch, input logic lsb, input logic single);
    int p;
    logic [11:0] res;
    logic live;
    logic exp_d;
    p = t % 32;
    res = levels[int'(ch) * 12 +: 12];
    live = !(single && t > 32);
    exp_d = 1'b0;
    if (p >= 20 && live) begin
      exp_d = lsb ? res[p - 20] : res[31 - p];
    end
    `CHK(strobe, (p == 16) && live, "sample strobe")
    `CHK(data, exp_d, "serial bit")
    `CHK({data_oe_n, strobe_oe_n}, 2'h0, "outputs not driven")
    if (p == 17 && live) begin
      `CHK(mux_sel, ch, "channel")
    end
  endtask : check_tick

  task automatic test_single();
    for (int c = 0; c < 4; c++) begin
      start(2'h0, c[1:0]);
      for (int t = 1; t <= 40; t++) begin
        wait_fall();
        check_tick(t, c[1:0], 1'b0, 1'b1);
      end
      stop();
    end
  endtask : test_single

  task automatic test_cont(input logic [1:0] mode, input logic lsb);
    int w;
    start(mode, 2'h0);
    for (int t = 1; t <= 96; t++) begin
      wait_fall();
      w = (t < 16) ? 0 : (t - 16) / 32;
      check_tick(t, 2'(w), lsb, 1'b0);
      if (t % 32 == 8) begin
        pins.chan_sel <= 2'((t - 8) / 32);
      end
    end
    stop();
  endtask : test_cont

  // Deselect in mid-word, then a fresh single-shot conversion
  task automatic test_abort();
    start(2'h3, 2'h2);
    for (int t = 1; t <= 24; t++) begin
      wait_fall();
      check_tick(t, 2'h2, 1'b0, 1'b0);
    end
    stop();
    start(2'h0, 2'h3);
    for (int t = 1; t <= 34; t++) begin
      wait_fall();
      check_tick(t, 2'h3, 1'b0, 1'b1);
    end
    stop();
  endtask : test_abort

  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge ref_clk);
    test_single();
    test_cont(2'h1, 1'b1);
    test_cont(2'h3, 1'b0);
    test_abort();
    wrap_up();
  end
endmodule : testbench
`undef CHK
`default_nettype wire
